// File: rtl/uem_pkg.sv
package uem_pkg;

	// configuration address and data widths
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BE_W   = 4;

	// register offsets in extended configuration space (byte addresses)
	localparam logic [11:0] CAP_HDR_OFS  = 12'h100;
	localparam logic [11:0] NEXT_PTR_OFS = 12'h102;
	localparam logic [11:0] FLAGS_OFS    = 12'h104;
	localparam logic [11:0] SUPPR_OFS    = 12'h108;

	// capability header word contents
	localparam logic [15:0] CAP_ID_VAL   = 16'h0001;
	localparam logic [3:0]  CAP_VER_VAL  = 4'h1;
	localparam logic [11:0] NEXT_VC_OFS  = 12'h150;
	localparam logic [11:0] NEXT_END_OFS = 12'h000;

	// error bit positions shared by the flag and suppress registers
	localparam int unsigned BIT_UNSUP   = 20;
	localparam int unsigned BIT_E2E_CRC = 19;
	localparam int unsigned BIT_MALFORM = 18;
	localparam int unsigned BIT_OVERRUN = 17;
	localparam int unsigned BIT_STRAY   = 16;
	localparam int unsigned BIT_CABORT  = 15;
	localparam int unsigned BIT_EXPIRY  = 14;
	localparam int unsigned BIT_FCPROT  = 13;
	localparam int unsigned BIT_POISON  = 12;
	localparam int unsigned BIT_DLLPROT = 4;

	// implemented bits; all others are reserved and read zero
	localparam logic [31:0] DEFINED_BITS = 32'h001f_f010;
	localparam logic [31:0] FLAGS_RST    = 32'h0000_0000;
	localparam logic [31:0] SUPPR_RST    = 32'h0000_0000;

	// first-error pointer width and reset value
	localparam int unsigned PTR_W   = 5;
	localparam logic [4:0]  PTR_RST = 5'h00;

	// pin synchroniser depth
	localparam int unsigned SYNC_STAGES = 3;

	// expand byte enables into a bit mask
	function automatic logic [31:0] uem_be_expand(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction : uem_be_expand

	// index of the lowest set bit, zero when none is set
	function automatic logic [4:0] uem_lowest_set(input logic [31:0] v);
		logic [4:0] idx;
		idx = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction : uem_lowest_set

endpackage : uem_pkg

// File: rtl/uem_pin_sync.sv
`timescale 1ns/100ps

// three-stage synchroniser for an asynchronous reset pin; the level only moves
// once the second and third stages agree, which filters one-cycle glitches
module uem_pin_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      level_o
);
	import uem_pkg::*;

	logic [SYNC_STAGES-1:0] stage_r;
	logic                   level_r;

	// shift chain; first stage feeds only the second
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			stage_r <= {SYNC_STAGES{RST_VAL}};
		end else begin
			stage_r <= {stage_r[SYNC_STAGES-2:0], pin_i};
		end
	end

	// accept a new level only when stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			level_r <= RST_VAL;
		end else if (stage_r[1] == stage_r[2]) begin
			level_r <= stage_r[2];
		end
	end

	assign level_o = level_r;

endmodule : uem_pin_sync

// File: rtl/uem_lane_merge.sv
`timescale 1ns/100ps

// byte-lane write helper: read/write merge and write-one-to-clear mask
module uem_lane_merge (
	input  wire logic [31:0] old_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  be_i,
	input  wire logic [31:0] keep_i,
	output logic      [31:0] merged_o,
	output logic      [31:0] clear_o
);
	import uem_pkg::*;

	logic [31:0] lane_m;

	// only enabled lanes and implemented bits take part
	always_comb begin
		lane_m   = uem_be_expand(be_i) & keep_i;
		merged_o = (old_i & ~lane_m) | (wdata_i & lane_m);
		clear_o  = wdata_i & lane_m;
	end

endmodule : uem_lane_merge

// File: rtl/uem_core.sv
// Function
// - with virtual-channel enable low, the next pointer field reads 000h
// - with virtual-channel enable high, the next pointer field reads 150h
// - capability version reads 1h; the whole pointer/version word is read-only
// - flag bits clear only on written ones, zeros keep them, reset to zero
// - unsupported request received sets flag bit 20
// - end-to-end CRC error sets flag bit 19
// - malformed packet sets flag bit 18
// - partner exceeding advertised credits sets flag bit 17
// - completion matching no outstanding request sets flag bit 16
// - returning a completer-abort status sets flag bit 15
// - completion time-out on an issued request sets flag bit 14
// - flow-control protocol violation, init or normal, sets flag bit 13
// - poisoned packet received sets flag bit 12
// - data link layer protocol error sets flag bit 4
// - bits 31:21, 11:5 and 3:0 of flags and suppress read zero, read-only
// - suppressed error sets no flag, no message, no header load, no pointer
// - suppress bits at 20..12 and 4 are read/write, reset to zero
// - flags and suppress reset by fundamental, global, power-on; not hot reset
`timescale 1ns/100ps

module uem_core (
	input  wire logic                       mclk_i,
	input  wire logic                       rst_i,
	input  wire logic                       fund_reset_pin_n_i,
	input  wire logic                       global_reset_pin_n_i,
	input  wire logic                       hot_reset_i,
	input  wire logic                       vchan_struct_present_enable_i,
	input  wire logic                       unsupported_request_evt_i,
	input  wire logic                       end_to_end_crc_fault_evt_i,
	input  wire logic                       malformed_packet_evt_i,
	input  wire logic                       credit_overrun_evt_i,
	input  wire logic                       stray_completion_evt_i,
	input  wire logic                       completer_abort_evt_i,
	input  wire logic                       completion_expiry_evt_i,
	input  wire logic                       flow_credit_protocol_evt_i,
	input  wire logic                       poisoned_packet_evt_i,
	input  wire logic                       dll_protocol_evt_i,
	input  wire logic                       cfg_req_i,
	input  wire logic                       cfg_wr_i,
	input  wire logic [uem_pkg::ADDR_W-1:0] cfg_addr_i,
	input  wire logic [uem_pkg::BE_W-1:0]   cfg_be_i,
	input  wire logic [uem_pkg::DATA_W-1:0] cfg_wdata_i,
	output logic                            cfg_ack_o,
	output logic      [uem_pkg::DATA_W-1:0] cfg_rdata_o,
	output logic                            err_report_o,
	output logic      [uem_pkg::DATA_W-1:0] err_report_vec_o,
	output logic                            hdr_log_load_o,
	output logic      [uem_pkg::PTR_W-1:0]  first_err_ptr_o,
	output logic                            first_err_valid_o
);
	import uem_pkg::*;

	// synchronised reset pin levels (active low, as on the pins)
	logic                fund_level;
	logic                glob_level;
	logic                sticky_rst;

	// register state
	logic [DATA_W-1:0]   flags_r;
	logic [DATA_W-1:0]   flags_nxt;
	logic [DATA_W-1:0]   suppr_r;
	logic [DATA_W-1:0]   suppr_nxt;

	// event gathering
	logic [DATA_W-1:0]   evt_vec;
	logic [DATA_W-1:0]   pass_vec;

	// config decode
	logic                hit_hdr;
	logic                hit_flags;
	logic                hit_suppr;
	logic                wr_flags;
	logic                wr_suppr;
	logic [DATA_W-1:0]   flags_clear;
	logic [DATA_W-1:0]   suppr_merged;
	logic [DATA_W-1:0]   rdata_nxt;
	logic [15:0]         next_ptr_ver;

	// response and report registers
	logic                cfg_ack_r;
	logic [DATA_W-1:0]   cfg_rdata_r;
	logic                err_report_r;
	logic [DATA_W-1:0]   err_report_vec_r;
	logic                hdr_log_load_r;
	logic [PTR_W-1:0]    first_err_ptr_r;
	logic                first_err_valid_r;
	logic                ptr_still_set;

	// reset pins come from off-chip, so they pass the three-stage filter
	uem_pin_sync #(
		.RST_VAL (1'b1)
	) u_fund_sync (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.pin_i   (fund_reset_pin_n_i),
		.level_o (fund_level)
	);

	uem_pin_sync #(
		.RST_VAL (1'b1)
	) u_glob_sync (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.pin_i   (global_reset_pin_n_i),
		.level_o (glob_level)
	);

	// the error registers survive a hot reset; only deeper resets clear them
	assign sticky_rst = rst_i | ~fund_level | ~glob_level;

	// place each error event at its flag position; reserved positions stay 0
	always_comb begin
		evt_vec              = 32'h0000_0000;
		evt_vec[BIT_UNSUP]   = unsupported_request_evt_i;
		evt_vec[BIT_E2E_CRC] = end_to_end_crc_fault_evt_i;
		evt_vec[BIT_MALFORM] = malformed_packet_evt_i;
		evt_vec[BIT_OVERRUN] = credit_overrun_evt_i;
		evt_vec[BIT_STRAY]   = stray_completion_evt_i;
		evt_vec[BIT_CABORT]  = completer_abort_evt_i;
		evt_vec[BIT_EXPIRY]  = completion_expiry_evt_i;
		evt_vec[BIT_FCPROT]  = flow_credit_protocol_evt_i;
		evt_vec[BIT_POISON]  = poisoned_packet_evt_i;
		evt_vec[BIT_DLLPROT] = dll_protocol_evt_i;
	end

	// suppressed errors go no further than this gate
	assign pass_vec = evt_vec & ~suppr_r & DEFINED_BITS;

	// address decode on dword boundaries; the pointer word is the upper half
	// of the dword at the capability header
	assign hit_hdr   = cfg_addr_i[11:2] == CAP_HDR_OFS[11:2];
	assign hit_flags = cfg_addr_i[11:2] == FLAGS_OFS[11:2];
	assign hit_suppr = cfg_addr_i[11:2] == SUPPR_OFS[11:2];
	assign wr_flags  = cfg_req_i & cfg_wr_i & hit_flags;
	assign wr_suppr  = cfg_req_i & cfg_wr_i & hit_suppr;

	// byte-lane handling for both writable registers
	uem_lane_merge u_flags_lanes (
		.old_i    (flags_r),
		.wdata_i  (cfg_wdata_i),
		.be_i     (cfg_be_i),
		.keep_i   (DEFINED_BITS),
		.merged_o (),
		.clear_o  (flags_clear)
	);

	uem_lane_merge u_suppr_lanes (
		.old_i    (suppr_r),
		.wdata_i  (cfg_wdata_i),
		.be_i     (cfg_be_i),
		.keep_i   (DEFINED_BITS),
		.merged_o (suppr_merged),
		.clear_o  ()
	);

	// flag update: clear by written ones, then set by passing events, so a
	// coinciding event always wins and is never lost
	always_comb begin
		flags_nxt = flags_r;
		if (wr_flags) begin
			flags_nxt = flags_nxt & ~flags_clear;
		end
		flags_nxt = (flags_nxt | pass_vec) & DEFINED_BITS;
	end

	// flag register, cleared by fundamental, global or power-on reset
	always_ff @(posedge mclk_i) begin
		if (sticky_rst) begin
			flags_r <= FLAGS_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// suppress register: plain read/write on implemented bits only
	always_comb begin
		suppr_nxt = suppr_r;
		if (wr_suppr) begin
			suppr_nxt = suppr_merged & DEFINED_BITS;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sticky_rst) begin
			suppr_r <= SUPPR_RST;
		end else begin
			suppr_r <= suppr_nxt;
		end
	end

	// pointer/version half-word; the enable comes from the general control
	// register elsewhere and is read live, so it takes effect at once
	always_comb begin
		if (vchan_struct_present_enable_i) begin
			next_ptr_ver = {NEXT_VC_OFS, CAP_VER_VAL};
		end else begin
			next_ptr_ver = {NEXT_END_OFS, CAP_VER_VAL};
		end
	end

	// read mux; writes to the header dword are dropped as it is read-only
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (hit_hdr) begin
			rdata_nxt = {next_ptr_ver, CAP_ID_VAL};
		end else if (hit_flags) begin
			rdata_nxt = flags_r & DEFINED_BITS;
		end else if (hit_suppr) begin
			rdata_nxt = suppr_r & DEFINED_BITS;
		end
	end

	// config answer: one cycle after the request, for reads and writes alike;
	// a hot reset drops an answer in flight since the link is going down
	always_ff @(posedge mclk_i) begin
		if (rst_i || hot_reset_i) begin
			cfg_ack_r <= 1'b0;
		end else begin
			cfg_ack_r <= cfg_req_i;
		end
	end

	// read data hold until the next request; write answers return zero
	always_ff @(posedge mclk_i) begin
		if (rst_i || hot_reset_i) begin
			cfg_rdata_r <= 32'h0000_0000;
		end else if (cfg_req_i) begin
			cfg_rdata_r <= cfg_wr_i ? 32'h0000_0000 : rdata_nxt;
		end
	end

	// error message request toward the message generator, one-cycle pulse;
	// the vector tells which unsuppressed errors caused it
	always_ff @(posedge mclk_i) begin
		if (rst_i || hot_reset_i) begin
			err_report_r     <= 1'b0;
			err_report_vec_r <= 32'h0000_0000;
		end else begin
			err_report_r     <= |pass_vec;
			err_report_vec_r <= pass_vec;
		end
	end

	// the pointed error is still outstanding while its flag stays set
	assign ptr_still_set = first_err_valid_r & flags_r[first_err_ptr_r];

	// first-error pointer: loaded only when no earlier error is outstanding;
	// among simultaneous errors the lowest bit position is taken
	always_ff @(posedge mclk_i) begin
		if (sticky_rst) begin
			first_err_ptr_r   <= PTR_RST;
			first_err_valid_r <= 1'b0;
		end else if (!ptr_still_set && |pass_vec) begin
			first_err_ptr_r   <= uem_lowest_set(pass_vec);
			first_err_valid_r <= 1'b1;
		end else if (!ptr_still_set) begin
			first_err_valid_r <= 1'b0;
		end
	end

	// header log load strobe follows the pointer update; a suppressed
	// error never reaches it, so the log keeps the first real error;
	// held low under the deep resets too, since the pointer is held there
	always_ff @(posedge mclk_i) begin
		if (sticky_rst || hot_reset_i) begin
			hdr_log_load_r <= 1'b0;
		end else begin
			hdr_log_load_r <= !ptr_still_set && |pass_vec;
		end
	end

	// every output straight from a flip-flop
	assign cfg_ack_o         = cfg_ack_r;
	assign cfg_rdata_o       = cfg_rdata_r;
	assign err_report_o      = err_report_r;
	assign err_report_vec_o  = err_report_vec_r;
	assign hdr_log_load_o    = hdr_log_load_r;
	assign first_err_ptr_o   = first_err_ptr_r;
	assign first_err_valid_o = first_err_valid_r;

endmodule : uem_core

// File: tb/uem_chk.sv
`timescale 1ns/100ps

module uem_chk import uem_pkg::*; (
	input wire logic        mclk_i,
	input wire logic        rst_i,
	input wire logic        hot_reset_i,
	input wire logic        vchan_struct_present_enable_i,
	input wire logic [9:0]  evt_i,
	input wire logic        cfg_req_i,
	input wire logic        cfg_wr_i,
	input wire logic [11:0] cfg_addr_i,
	input wire logic        cfg_ack_o,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic        err_report_o,
	input wire logic [31:0] err_report_vec_o,
	input wire logic        hdr_log_load_o,
	input wire logic        first_err_valid_o
);
	logic [31:0] evt_vec;
	// events placed at their flag positions
	assign evt_vec = {11'h000, evt_i[9:1], 7'h00, evt_i[0], 4'h0};
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		cfg_req_i && !hot_reset_i;
	endsequence
	sequence s_rd_ptr;
		s_take ##0 !cfg_wr_i && cfg_addr_i[11:2] == 10'h040;
	endsequence
	a_ack_one_cycle: assert property (s_take |=> cfg_ack_o) else $error("ack missing");
	a_ack_no_cause: assert property (!cfg_req_i |=> !cfg_ack_o) else $error("stray ack");
	a_ptr_end_list: assert property (s_rd_ptr ##0 !vchan_struct_present_enable_i
		|=> cfg_rdata_o[31:16] == 16'h0001) else $error("end pointer wrong");
	a_ptr_vc_list: assert property (s_rd_ptr ##0 vchan_struct_present_enable_i
		|=> cfg_rdata_o[31:16] == 16'h1501) else $error("vc pointer wrong");
	a_rsvd_read_zero: assert property (s_take ##0 !cfg_wr_i &&
		(cfg_addr_i[11:2] == 10'h041 || cfg_addr_i[11:2] == 10'h042)
		|=> (cfg_rdata_o & ~DEFINED_BITS) == 32'h0) else $error("reserved bit set");
	a_write_rdata_zero: assert property (s_take ##0 cfg_wr_i |=> cfg_rdata_o == 32'h0)
		else $error("write answer data");
	a_vec_has_cause: assert property ((err_report_vec_o & ~$past(evt_vec)) == 32'h0)
		else $error("report without event");
	a_report_tied_vec: assert property (err_report_o == (|err_report_vec_o))
		else $error("report and vector disagree");
	a_load_has_valid: assert property (hdr_log_load_o |-> first_err_valid_o)
		else $error("load without pointer");
endmodule : uem_chk

bind uem_core uem_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .hot_reset_i(hot_reset_i),
	.vchan_struct_present_enable_i(vchan_struct_present_enable_i),
	.evt_i({unsupported_request_evt_i, end_to_end_crc_fault_evt_i, malformed_packet_evt_i,
		credit_overrun_evt_i, stray_completion_evt_i, completer_abort_evt_i,
		completion_expiry_evt_i, flow_credit_protocol_evt_i, poisoned_packet_evt_i,
		dll_protocol_evt_i}),
	.cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
	.cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o), .err_report_o(err_report_o),
	.err_report_vec_o(err_report_vec_o), .hdr_log_load_o(hdr_log_load_o),
	.first_err_valid_o(first_err_valid_o));

// File: tb/uem_cfg_host.sv
`timescale 1ns/100ps

module uem_cfg_host (
	input  wire logic        mclk_i,
	input  wire logic        cfg_ack_i,
	input  wire logic [31:0] cfg_rdata_i,
	output logic             cfg_req_o,
	output logic             cfg_wr_o,
	output logic      [11:0] cfg_addr_o,
	output logic      [3:0]  cfg_be_o,
	output logic      [31:0] cfg_wdata_o
);
	initial begin
		cfg_req_o = 1'b0;
		cfg_wr_o = 1'b0;
		cfg_addr_o = 12'h000;
		cfg_be_o = 4'h0;
		cfg_wdata_o = 32'h0;
	end
	// one access, called at a falling edge; answer has a fixed one-cycle latency,
	// so it is taken at the next falling edge; idle address and write data are scrambled
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] b, input int gap, output logic [31:0] q, output logic k);
		cfg_req_o = 1'b1;
		cfg_wr_o = w;
		cfg_addr_o = a;
		cfg_be_o = b;
		cfg_wdata_o = d;
		@(negedge mclk_i);
		k = cfg_ack_i;
		q = cfg_rdata_i;
		cfg_req_o = 1'b0;
		cfg_addr_o = ~a;
		cfg_wdata_o = ~d;
		repeat (gap + 1) @(negedge mclk_i);
	endtask : xfer
endmodule : uem_cfg_host

// File: tb/uncorrectable_error_status_mask_tb.sv
`timescale 1ns/100ps

module uncorrectable_error_status_mask_tb;
	logic        mclk_i, rst_i, fund_n, glob_n, hot, vchan;
	logic [9:0]  ev;
	logic        req, wr, ack, report, hdr, fvalid;
	logic [11:0] addr;
	logic [3:0]  be;
	logic [31:0] wdata, rdata, vec;
	logic [4:0]  ptr;
	int          bad_count, cmp_count;
	int          pos[10] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 4};

	uem_core dut (.mclk_i(mclk_i), .rst_i(rst_i), .fund_reset_pin_n_i(fund_n),
		.global_reset_pin_n_i(glob_n), .hot_reset_i(hot),
		.vchan_struct_present_enable_i(vchan), .unsupported_request_evt_i(ev[0]),
		.end_to_end_crc_fault_evt_i(ev[1]), .malformed_packet_evt_i(ev[2]),
		.credit_overrun_evt_i(ev[3]), .stray_completion_evt_i(ev[4]),
		.completer_abort_evt_i(ev[5]), .completion_expiry_evt_i(ev[6]),
		.flow_credit_protocol_evt_i(ev[7]), .poisoned_packet_evt_i(ev[8]),
		.dll_protocol_evt_i(ev[9]), .cfg_req_i(req), .cfg_wr_i(wr), .cfg_addr_i(addr),
		.cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_ack_o(ack), .cfg_rdata_o(rdata),
		.err_report_o(report), .err_report_vec_o(vec), .hdr_log_load_o(hdr),
		.first_err_ptr_o(ptr), .first_err_valid_o(fvalid));
	uem_cfg_host host (.mclk_i(mclk_i), .cfg_ack_i(ack), .cfg_rdata_i(rdata),
		.cfg_req_o(req), .cfg_wr_o(wr), .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wdata));

	always #2 mclk_i = ~mclk_i;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input int gap = 0);
		logic [31:0] q;
		logic        k;
		host.xfer(1'b0, a, 32'h0, 4'hf, gap, q, k);
		chk("read ack", 32'h1, {31'h0, k});
		chk("read data", e, q);
	endtask : rd
	task automatic wt(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
		logic [31:0] q;
		logic        k;
		host.xfer(1'b1, a, d, b, 0, q, k);
		chk("write ack", 32'h1, {31'h0, k});
	endtask : wt
	// one-cycle event; its report shows in the cycle after
	task automatic pulse(input int i, input logic [31:0] e, input logic h);
		ev[i] = 1'b1;
		@(negedge mclk_i);
		ev[i] = 1'b0;
		chk("report vector", e, vec);
		chk("report", {31'h0, |e}, {31'h0, report});
		chk("header load", {31'h0, h}, {31'h0, hdr});
		@(negedge mclk_i);
	endtask : pulse
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		#40000;
		bad_count++;
		close_out();
	end

	initial begin
		{mclk_i, fund_n, glob_n, hot, vchan, ev} = {1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 10'h000};
		rst_i = 1'b1;
		repeat (3) @(negedge mclk_i);
		rst_i = 1'b0;
		rd(12'h104, 32'h0);
		rd(12'h108, 32'h0);
		rd(12'h10c, 32'h0, 3);
		rd(12'h100, 32'h0001_0001);
		vchan = 1'b1;
		rd(12'h102, 32'h1501_0001);
		wt(12'h100, 32'h0);
		rd(12'h100, 32'h1501_0001);
		wt(12'h108, 32'hffff_ffff);
		rd(12'h108, 32'h001f_f010);
		wt(12'h108, 32'h0, 4'h2);
		rd(12'h108, 32'h001f_0010);
		wt(12'h104, 32'hffff_ffff);
		wt(12'h108, 32'h0);
		for (int i = 0; i < 10; i++) begin
			pulse(i, 32'h1 << pos[i], 1'b1);
			chk("pointer", pos[i], {27'h0, ptr});
			chk("pointer valid", 32'h1, {31'h0, fvalid});
			rd(12'h104, 32'h1 << pos[i]);
			wt(12'h104, 32'h1 << pos[i]);
			rd(12'h104, 32'h0);
			chk("pointer valid", 32'h0, {31'h0, fvalid});
		end
		pulse(0, 32'h0010_0000, 1'b1);
		wt(12'h104, 32'h0);
		rd(12'h104, 32'h0010_0000);
		// event lands on the same edge as its clearing write
		ev[0] = 1'b1;
		fork
			wt(12'h104, 32'h0010_0000);
			@(negedge mclk_i) ev[0] = 1'b0;
		join
		rd(12'h104, 32'h0010_0000);
		wt(12'h104, 32'h0010_0000);
		wt(12'h108, 32'h0000_1000);
		pulse(8, 32'h0, 1'b0);
		rd(12'h104, 32'h0);
		pulse(9, 32'h10, 1'b1);
		hot = 1'b1;
		@(negedge mclk_i);
		hot = 1'b0;
		rd(12'h104, 32'h10);
		rd(12'h108, 32'h0000_1000);
		for (int p = 0; p < 2; p++) begin
			pulse(9, 32'h10, p == 1);
			wt(12'h108, 32'h0000_1010);
			{glob_n, fund_n} = p ? 2'b01 : 2'b10;
			repeat (4) @(negedge mclk_i);
			{glob_n, fund_n} = 2'b11;
			repeat (8) @(negedge mclk_i);
			rd(12'h104, 32'h0);
			rd(12'h108, 32'h0);
		end
		close_out();
	end
endmodule : uncorrectable_error_status_mask_tb
